// file: rtl/jtc_tap_ctrl.sv
// Purpose: Test access port controller with instruction register and data paths.
// Assumes: tms and tdi change away from rising tck; core signals are on sys_clk.
// Notes:   Update data crosses to sys_clk as a quasi-static word.
`timescale 1ns/10ps
`default_nettype none
`include "jtc_consts.svh"
module jtc_tap_ctrl #(
  parameter int          PIN_COUNT = 4,
  // Identification value is arbitrary.
  parameter logic [31:0] ID_CODE   = `JTC_IDCODE_DEFAULT
) (
  // Test port
  input  wire logic                    tck,
  input  wire logic                    trstN,
  input  wire logic                    tms,
  input  wire logic                    tdi,
  output logic                         tdoOut,
  output logic                         tdoOe,
  // System clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  // Core side of the user pins
  input  wire logic [PIN_COUNT-1:0]    coreOutputValue,
  input  wire logic [PIN_COUNT-1:0]    coreOutputEnable,
  input  wire logic [PIN_COUNT-1:0]    keeperEnable,
  input  wire logic [PIN_COUNT-1:0]    pinIn,
  input  wire logic [`JTC_DR_WIDTH-1:0] userCode,
  // Pin drive
  output logic      [PIN_COUNT-1:0]    pinOut,
  output logic      [PIN_COUNT-1:0]    pinOe,
  output logic      [PIN_COUNT-1:0]    pinKeeperOn,
  // Test-clock side controls
  output logic                         highzCtrl,
  output logic                         ioCsrShift,
  output logic                         ioCsrData,
  // System-clock side controls
  output logic                         reconfigTrigger,
  output logic                         ioCsrSelect
);
  import jtc_pkg::*;

  localparam int BSR_W = 3 * PIN_COUNT;

  // Power-on reset is brought into the test clock domain.
  logic porTck;
  jtc_sync #(.W(1)) u_por_sync (
    .clk  (tck),
    .rst  (1'h0),
    .din  (sys_rst),
    .dout (porTck)
  );

  // Pin snapshot: per pin the input level, core enable and core value.
  logic [BSR_W-1:0] pinSnap;
  logic [BSR_W-1:0] pinSnapTck;
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_snap
      assign pinSnap[3*gi]   = pinIn[gi];
      assign pinSnap[3*gi+1] = coreOutputEnable[gi];
      assign pinSnap[3*gi+2] = coreOutputValue[gi];
    end
  endgenerate
  jtc_sync #(.W(BSR_W)) u_pin_sync (
    .clk  (tck),
    .rst  (porTck),
    .din  (pinSnap),
    .dout (pinSnapTck)
  );

  logic [`JTC_DR_WIDTH-1:0] userTck;
  jtc_sync #(.W(`JTC_DR_WIDTH)) u_user_sync (
    .clk  (tck),
    .rst  (porTck),
    .din  (userCode),
    .dout (userTck)
  );

  // Controller state.
  jtc_tap_state_type stateReg;
  jtc_tap_state_type stateNext;

  always_ff @(posedge tck or negedge trstN) begin
    if (!trstN) begin
      stateReg <= TS_RESET;  // [RQ4] [RQ5]
    end else if (porTck) begin
      stateReg <= TS_RESET;  // [RQ3]
    end else begin
      stateReg <= stateNext;  // [RQ1]
    end
  end

  always_comb begin
    stateNext = stateReg;
    unique case (stateReg)
      TS_RESET:    stateNext = tms ? TS_RESET : TS_IDLE;  // [RQ5]
      TS_IDLE:     stateNext = tms ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR:   stateNext = tms ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR:   stateNext = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
      TS_SHIFT_DR: stateNext = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
      TS_EXIT1_DR: stateNext = tms ? TS_UPD_DR : TS_PAUSE_DR;
      TS_PAUSE_DR: stateNext = tms ? TS_EXIT2_DR : TS_PAUSE_DR;
      TS_EXIT2_DR: stateNext = tms ? TS_UPD_DR : TS_SHIFT_DR;
      TS_UPD_DR:   stateNext = tms ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR:   stateNext = tms ? TS_RESET : TS_CAP_IR;  // [RQ4]
      TS_CAP_IR:   stateNext = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
      TS_SHIFT_IR: stateNext = tms ? TS_EXIT1_IR : TS_SHIFT_IR;  // [RQ9] [RQ11]
      TS_EXIT1_IR: stateNext = tms ? TS_UPD_IR : TS_PAUSE_IR;
      TS_PAUSE_IR: stateNext = tms ? TS_EXIT2_IR : TS_PAUSE_IR;
      TS_EXIT2_IR: stateNext = tms ? TS_UPD_IR : TS_SHIFT_IR;
      TS_UPD_IR:   stateNext = tms ? TS_SEL_DR : TS_IDLE;
    endcase
  end

  logic isReset;
  logic isCapDr;
  logic isShiftDr;
  logic isUpdDr;
  logic isCapIr;
  logic isShiftIr;
  logic isUpdIr;
  logic inShift;
  assign isReset   = (stateReg == TS_RESET);
  assign isCapDr   = (stateReg == TS_CAP_DR);
  assign isShiftDr = (stateReg == TS_SHIFT_DR);
  assign isUpdDr   = (stateReg == TS_UPD_DR);
  assign isCapIr   = (stateReg == TS_CAP_IR);
  assign isShiftIr = (stateReg == TS_SHIFT_IR);
  assign isUpdIr   = (stateReg == TS_UPD_IR);
  assign inShift   = isShiftIr | isShiftDr;

  // Instruction shift register.
  jtc_shift_if #(.W(`JTC_IR_WIDTH)) irBus ();
  assign irBus.capture      = isCapIr;  // [RQ25]
  assign irBus.shift        = isShiftIr;  // [RQ10] [RQ11]
  assign irBus.serialIn     = tdi;
  assign irBus.captureValue = `JTC_IR_CAPTURE;
  jtc_shift_reg #(.W(`JTC_IR_WIDTH), .RESET_VALUE(`JTC_INSTR_IDCODE)) u_ir (
    .clk  (tck),
    .rstN (trstN),
    .sif  (irBus.sreg)
  );

  // Active instruction, applied only at update or reset so shifting never disturbs the mode.
  logic [`JTC_IR_WIDTH-1:0] instrReg;
  jtc_instr_type            instrKind;
  always_ff @(posedge tck or negedge trstN) begin
    if (!trstN) begin
      instrReg <= `JTC_INSTR_IDCODE;
    end else if (porTck || isReset) begin
      instrReg <= `JTC_INSTR_IDCODE;  // [RQ2]
    end else if (isUpdIr) begin
      instrReg <= irBus.parallel;
    end
  end
  assign instrKind = jtc_decode(instrReg);

  logic selBsr;
  logic selDr32;
  logic selBypass;
  logic selCfgIo;
  logic selForce;
  assign selBsr    = (instrKind == IK_SAMPLE) | (instrKind == IK_EXTEST);  // [RQ12] [RQ13]
  assign selDr32   = (instrKind == IK_USER) | (instrKind == IK_ID);  // [RQ15] [RQ16]
  assign selBypass = !(selBsr | selDr32);  // [RQ14] [RQ17] [RQ18] [RQ26]
  assign selCfgIo  = (instrKind == IK_CFGIO);
  assign selForce  = (instrKind == IK_EXTEST) | (instrKind == IK_CLAMP);  // [RQ13] [RQ18]

  // Identification and user-code path.
  jtc_shift_if #(.W(`JTC_DR_WIDTH)) drBus ();
  assign drBus.capture      = isCapDr & selDr32;
  assign drBus.shift        = isShiftDr & selDr32;
  assign drBus.serialIn     = tdi;
  assign drBus.captureValue = (instrKind == IK_USER) ? userTck : ID_CODE;  // [RQ15] [RQ16]
  jtc_shift_reg #(.W(`JTC_DR_WIDTH), .RESET_VALUE(`JTC_DR_RESET)) u_dr (
    .clk  (tck),
    .rstN (trstN),
    .sif  (drBus.sreg)
  );

  // One-bit bypass.
  logic bypassReg;
  always_ff @(posedge tck or negedge trstN) begin
    if (!trstN) begin
      bypassReg <= `JTC_BYPASS_RESET;
    end else if (isCapDr && selBypass) begin
      bypassReg <= `JTC_BYPASS_RESET;
    end else if (isShiftDr && selBypass) begin
      bypassReg <= tdi;  // [RQ23]
    end
  end

  // Boundary capture and update registers; the data clock enables capture and shift.
  logic             dataRegisterClock;
  logic [BSR_W-1:0] bsrCapReg;
  logic [BSR_W-1:0] bsrUpdReg;
  assign dataRegisterClock = (isCapDr | isShiftDr) & selBsr;  // [RQ22]
  always_ff @(posedge tck or negedge trstN) begin
    if (!trstN) begin
      bsrCapReg <= '0;
      bsrUpdReg <= '0;
    end else begin
      if (dataRegisterClock && isCapDr) begin
        bsrCapReg <= pinSnapTck;  // [RQ22]
      end else if (dataRegisterClock) begin
        bsrCapReg <= {tdi, bsrCapReg[BSR_W-1:1]};
      end
      if (isUpdDr && selBsr) begin
        bsrUpdReg <= bsrCapReg;  // [RQ12]
      end
    end
  end

  // Serial output, launched on the falling edge.
  logic tdoNext;
  logic tdoOutReg;
  logic tdoOeReg;
  assign tdoNext = isShiftIr ? irBus.serialOut :  // [RQ9]
                   selBsr    ? bsrCapReg[0] :
                   selDr32   ? drBus.serialOut : bypassReg;
  always_ff @(negedge tck or negedge trstN) begin
    if (!trstN) begin
      tdoOutReg <= '0;
      tdoOeReg  <= '0;
    end else begin
      tdoOutReg <= inShift ? tdoNext : 1'h0;  // [RQ23]
      tdoOeReg  <= inShift;  // [RQ7] [RQ8]
    end
  end
  assign tdoOut = tdoOutReg;
  assign tdoOe  = tdoOeReg;

  // Mode levels and events on the test clock.
  logic highzCtrlReg;
  logic forceReg;
  logic cfgIoReg;
  logic reconfigTogReg;
  logic ioCsrShiftReg;
  logic ioCsrDataReg;
  logic reconfigLoad;
  assign reconfigLoad = isUpdIr & (jtc_decode(irBus.parallel) == IK_RECONFIG);
  always_ff @(posedge tck or negedge trstN) begin
    if (!trstN) begin
      highzCtrlReg   <= '0;
      forceReg       <= '0;
      cfgIoReg       <= '0;
      reconfigTogReg <= '0;
      ioCsrShiftReg  <= '0;
      ioCsrDataReg   <= '0;
    end else begin
      highzCtrlReg  <= (instrKind == IK_HIGHZ);  // [RQ24] [RQ17]
      forceReg      <= selForce;
      cfgIoReg      <= selCfgIo;
      ioCsrShiftReg <= isShiftDr & selCfgIo;  // [RQ20]
      ioCsrDataReg  <= tdi;
      if (reconfigLoad) begin
        reconfigTogReg <= ~reconfigTogReg;  // [RQ19]
      end
    end
  end
  assign highzCtrl  = highzCtrlReg;
  assign ioCsrShift = ioCsrShiftReg;
  assign ioCsrData  = ioCsrDataReg;

  // Crossing into the system clock.
  logic [3:0]       modeSys;
  logic [BSR_W-1:0] updSys;
  jtc_sync #(.W(4)) u_mode_sync (
    .clk  (sys_clk),
    .rst  (sys_rst),
    .din  ({highzCtrlReg, forceReg, cfgIoReg, reconfigTogReg}),
    .dout (modeSys)
  );
  jtc_sync #(.W(BSR_W)) u_upd_sync (
    .clk  (sys_clk),
    .rst  (sys_rst),
    .din  (bsrUpdReg),
    .dout (updSys)
  );

  logic                 highzSys;
  logic                 forceSys;
  logic [PIN_COUNT-1:0] pinOutNext;
  logic [PIN_COUNT-1:0] pinOeNext;
  logic [PIN_COUNT-1:0] keeperNext;
  assign highzSys = modeSys[3];
  assign forceSys = modeSys[2];
  generate
    for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin
      // A one in the enable update bit floats the pin.
      assign pinOeNext[gi]  = highzSys ? 1'h0 :
                              forceSys ? ~updSys[3*gi+1] : coreOutputEnable[gi];  // [RQ17]
      assign pinOutNext[gi] = forceSys ? updSys[3*gi+2] : coreOutputValue[gi];  // [RQ13]
      assign keeperNext[gi] = (highzSys | forceSys) & ~pinOeNext[gi] & keeperEnable[gi];  // [RQ21]
    end
  endgenerate

  logic reconfigSeenReg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pinOut          <= '0;
      pinOe           <= '0;
      pinKeeperOn     <= '0;
      reconfigSeenReg <= '0;
      reconfigTrigger <= '0;
    end else begin
      pinOut          <= pinOutNext;
      pinOe           <= pinOeNext;
      pinKeeperOn     <= keeperNext;
      reconfigSeenReg <= modeSys[0];
      reconfigTrigger <= modeSys[0] ^ reconfigSeenReg;  // [RQ19]
    end
  end
  assign ioCsrSelect = modeSys[1];  // [RQ20]

  // Checks on the test clock.
  property p_five_ones;
    @(posedge tck) disable iff (!trstN) tms [*5] |=> isReset;
  endproperty
  a_five_ones: assert property (p_five_ones)  // [RQ4]
    else $error("five high mode-select cycles did not reach reset");

  property p_stay_reset;
    @(posedge tck) disable iff (!trstN) (isReset && tms) |=> isReset;
  endproperty
  a_stay_reset: assert property (p_stay_reset)  // [RQ5]
    else $error("controller left reset with mode select high");

  property p_reset_instr;
    @(posedge tck) disable iff (!trstN) isReset |=> (instrReg == `JTC_INSTR_IDCODE);
  endproperty
  a_reset_instr: assert property (p_reset_instr)  // [RQ2]
    else $error("reset state did not load identification instruction");

  sequence s_to_shift_ir;
    (isReset && !tms && !porTck) ##1 (tms && !porTck) [*2] ##1 (!tms && !porTck) [*2];
  endsequence
  property p_walk_ir;
    @(posedge tck) disable iff (!trstN) s_to_shift_ir |=> isShiftIr;
  endproperty
  a_walk_ir: assert property (p_walk_ir)  // [RQ1]
    else $error("pattern 01100 did not reach shift-instruction");

  property p_shift_ir_hold;
    @(posedge tck) disable iff (!trstN || porTck) (isShiftIr && !tms) |=> isShiftIr;
  endproperty
  a_shift_ir_hold: assert property (p_shift_ir_hold)  // [RQ9]
    else $error("shift-instruction left with mode select low");

  property p_last_bit;
    @(posedge tck) disable iff (!trstN || porTck)
      (isShiftIr && tms) |=> (stateReg == TS_EXIT1_IR) &&
                             (irBus.parallel[`JTC_IR_WIDTH-1] == $past(tdi));
  endproperty
  a_last_bit: assert property (p_last_bit)  // [RQ11]
    else $error("last instruction bit not shifted on exit edge");

  property p_oe_on;
    @(negedge tck) disable iff (!trstN) inShift |-> ##1 tdoOeReg;
  endproperty
  a_oe_on: assert property (p_oe_on)  // [RQ8]
    else $error("output driver not on after shift state entered");

  property p_oe_off;
    @(negedge tck) disable iff (!trstN) !inShift |-> ##1 !tdoOeReg;
  endproperty
  a_oe_off: assert property (p_oe_off)  // [RQ7]
    else $error("output driven outside shift states");

  property p_bypass_path;
    @(posedge tck) disable iff (!trstN) (isShiftDr && selBypass) |=> (bypassReg == $past(tdi));
  endproperty
  a_bypass_path: assert property (p_bypass_path)  // [RQ23]
    else $error("bypass register did not take input bit");

  property p_highz_ctrl;
    @(posedge tck) disable iff (!trstN) (instrKind == IK_HIGHZ) |=> highzCtrlReg;
  endproperty
  a_highz_ctrl: assert property (p_highz_ctrl)  // [RQ24]
    else $error("high-impedance control missing");

  property p_capture_ir;
    @(posedge tck) disable iff (!trstN) isCapIr |=> (irBus.parallel[1:0] == `JTC_IR_LOW_PATTERN);
  endproperty
  a_capture_ir: assert property (p_capture_ir)  // [RQ25]
    else $error("instruction capture pattern wrong");

  property p_reconfig_tog;
    @(posedge tck) disable iff (!trstN) reconfigLoad |=> (reconfigTogReg != $past(reconfigTogReg));
  endproperty
  a_reconfig_tog: assert property (p_reconfig_tog)  // [RQ19]
    else $error("reconfiguration event not raised");

  property p_c_shift_ir;
    @(posedge tck) disable iff (!trstN) isShiftIr ##1 (stateReg == TS_EXIT1_IR);
  endproperty
  c_shift_ir: cover property (p_c_shift_ir);
  property p_c_bypass;
    @(posedge tck) disable iff (!trstN) isShiftDr && selBypass;
  endproperty
  c_bypass: cover property (p_c_bypass);
  property p_c_sample;
    @(posedge tck) disable iff (!trstN) isCapDr && (instrKind == IK_SAMPLE);
  endproperty
  c_sample: cover property (p_c_sample);
  property p_c_reconfig;
    @(posedge tck) disable iff (!trstN) reconfigLoad;
  endproperty
  c_reconfig: cover property (p_c_reconfig);
endmodule
`default_nettype wire

// file: rtl/jtc_consts.svh
// Purpose: Shared constants for the test access port controller.
// Assumes: Included by the package and by the top module.
// Notes:   Holds instruction codes, register widths and reset values.
// Functional notes
// RQ1 - Sixteen-state controller steps on rising test clock, steered by mode select.
// RQ2 - Test-logic-reset disables scan logic and loads the identification instruction.
// RQ3 - Controller starts in test-logic-reset after power-up.
// RQ4 - Five high mode-select cycles or low test reset force test-logic-reset.
// RQ5 - Controller stays in test-logic-reset while mode select high or reset low.
// RQ6 - Host walks from reset to shift-instruction with mode select 01100.
// RQ7 - Test data output is undriven outside the two shift states.
// RQ8 - Output driver switches on and off at falling edges after shift changes.
// RQ9 - Shift-instruction sends prior instruction contents out, holds while select low; the code shifts out the captured 10'h001 pattern instead.
// RQ10 - Instruction bits are taken from test data input on rising edges.
// RQ11 - Last instruction bit shifts on the edge that moves to exit-1-instruction.
// RQ12 - Code 005 selects sample/preload: snapshot pins, preload pattern, no disturbance.
// RQ13 - Code 00f selects external test: force update pattern, capture pin levels.
// RQ14 - All-ones code puts one-bit bypass in path, normal operation continues.
// RQ15 - Code 007 shifts out the 32-bit user-code register.
// RQ16 - Code 006 shifts out the identification-code register.
// RQ17 - Code 00b selects bypass and floats all user pins.
// RQ18 - Code 00a selects bypass and holds pins at boundary register levels.
// RQ19 - Code 001 triggers reconfiguration like a restart pin pulse.
// RQ20 - Code 00d lets the I/O configuration chain reload over the port.
// RQ21 - Enabled bus-hold or pull-up wins over forced high impedance.
// RQ22 - Sample capture loads pin level, core enable and value using data clock.
// RQ23 - Bypass takes input on rising edge, presents it on next falling edge.
// RQ24 - High-impedance control is asserted while that instruction is active.
// RQ25 - Capture-instruction loads a pattern ending in binary 01.
// RQ26 - Unassigned instruction codes act like bypass.
`ifndef JTC_CONSTS_SVH
`define JTC_CONSTS_SVH
`define JTC_IR_WIDTH        10
`define JTC_DR_WIDTH        32
`define JTC_INSTR_SAMPLE    10'h005
`define JTC_INSTR_EXTEST    10'h00f
`define JTC_INSTR_BYPASS    10'h3ff
`define JTC_INSTR_USERCODE  10'h007
`define JTC_INSTR_IDCODE    10'h006
`define JTC_INSTR_HIGHZ     10'h00b
`define JTC_INSTR_CLAMP     10'h00a
`define JTC_INSTR_RECONFIG  10'h001
`define JTC_INSTR_CONFIG_IO 10'h00d
`define JTC_IR_CAPTURE      10'h001
`define JTC_IR_LOW_PATTERN  2'h1
`define JTC_BYPASS_RESET    1'h0
`define JTC_DR_RESET        32'h0000_0000
`define JTC_IDCODE_DEFAULT  32'h0bad_c001
`endif

// file: rtl/jtc_pkg.sv
// Purpose: Types and instruction decode for the test access port controller.
// Assumes: jtc_consts.svh supplies the codes.
// Notes:   Unknown codes decode to bypass.
`include "jtc_consts.svh"
package jtc_pkg;
  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SHIFT_DR, TS_EXIT1_DR, TS_PAUSE_DR,
    TS_EXIT2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SHIFT_IR, TS_EXIT1_IR,
    TS_PAUSE_IR, TS_EXIT2_IR, TS_UPD_IR
  } jtc_tap_state_type;

  typedef enum logic [3:0] {
    IK_SAMPLE, IK_EXTEST, IK_BYPASS, IK_USER, IK_ID, IK_HIGHZ, IK_CLAMP,
    IK_RECONFIG, IK_CFGIO
  } jtc_instr_type;

  function automatic jtc_instr_type jtc_decode(input logic [`JTC_IR_WIDTH-1:0] code);
    jtc_instr_type kind;
    case (code)
      `JTC_INSTR_SAMPLE:    kind = IK_SAMPLE;
      `JTC_INSTR_EXTEST:    kind = IK_EXTEST;
      `JTC_INSTR_USERCODE:  kind = IK_USER;
      `JTC_INSTR_IDCODE:    kind = IK_ID;
      `JTC_INSTR_HIGHZ:     kind = IK_HIGHZ;
      `JTC_INSTR_CLAMP:     kind = IK_CLAMP;
      `JTC_INSTR_RECONFIG:  kind = IK_RECONFIG;
      `JTC_INSTR_CONFIG_IO: kind = IK_CFGIO;
      default:              kind = IK_BYPASS;
    endcase
    return kind;
  endfunction
endpackage

// file: rtl/jtc_shift_if.sv
// Purpose: Control and data of one capture-and-shift register.
// Assumes: Driven by the controller, served by jtc_shift_reg.
// Notes:   Shifting moves toward bit zero; bit zero is the serial output.
`timescale 1ns/10ps
`default_nettype none
interface jtc_shift_if #(parameter int W = 10);
  logic         capture;
  logic         shift;
  logic         serialIn;
  logic [W-1:0] captureValue;
  logic         serialOut;
  logic [W-1:0] parallel;
  modport ctrl (output capture, shift, serialIn, captureValue, input serialOut, parallel);
  modport sreg (input capture, shift, serialIn, captureValue, output serialOut, parallel);
endinterface
`default_nettype wire

// file: rtl/jtc_sync.sv
// Purpose: Two-flop level synchroniser.
// Assumes: Each bit is a level that is stable long enough to be seen.
// Notes:   Multi-bit use is only safe for quasi-static words.
`timescale 1ns/10ps
`default_nettype none
module jtc_sync #(parameter int W = 1) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] metaReg;
  always_ff @(posedge clk) begin
    if (rst) begin
      metaReg <= '0;
      dout    <= '0;
    end else begin
      metaReg <= din;
      dout    <= metaReg;
    end
  end
endmodule
`default_nettype wire

// file: rtl/jtc_shift_reg.sv
// Purpose: Capture-and-shift register clocked by the test clock.
// Assumes: Capture and shift are never both high.
// Notes:   Asynchronous active-low reset to a parameter value.
`timescale 1ns/10ps
`default_nettype none
module jtc_shift_reg #(
  parameter int           W           = 10,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstN,
  // Register port
  jtc_shift_if.sreg sif
);
  logic [W-1:0] dataReg;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      dataReg <= RESET_VALUE;
    end else if (sif.capture) begin
      dataReg <= sif.captureValue;
    end else if (sif.shift) begin
      dataReg <= {sif.serialIn, dataReg[W-1:1]};
    end
  end
  assign sif.serialOut = dataReg[0];
  assign sif.parallel  = dataReg;
endmodule
`default_nettype wire

// file: sim/jtc_host_model.sv
// Purpose: Scan host that drives the test port of the controller.
// Assumes: The bench issues one request at a time.
// Notes:   The test clock stands still outside frames.
`timescale 1ns/10ps
`default_nettype none
module jtc_host_model (
  // Test port
  output logic      tck,
  output logic      trstN,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdoOut,
  input  wire logic tdoOe
);
  initial begin
    tck = 1'h0;
    trstN = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end

  // Inputs move just after the falling edge, far from the rising sample.
  // A released output reads as the inverse of its last level.
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #5 tck = 1'h1;
    #6 tck = 1'h0;
    #1 q = tdoOe ? tdoOut : ~tdoOut;
  endtask

  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    step(1'h1, 1'h0, b);
    if (ir) begin
      step(1'h1, 1'h0, b);
    end
    step(1'h0, 1'h0, b);
    step(1'h0, 1'h0, b);
    dout[0] = b;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      if (i < n - 1) begin
        dout[i + 1] = b;
      end
    end
    step(1'h1, 1'h0, b);
    step(1'h0, 1'h0, b);
    step(1'h0, 1'h0, b);
  endtask

  // Five high steps, optionally with the reset pin low, then park in idle.
  task automatic reset_tap(input logic pin);
    logic b;
    trstN = ~pin;
    repeat (5) step(1'h1, 1'h0, b);
    trstN = 1'h1;
    step(1'h0, 1'h0, b);
  endtask
endmodule
`default_nettype wire

// file: sim/jtag_tap_instruction_control_test.sv
// Purpose: Self-checking bench for the test access port controller.
// Assumes: Host model owns the test port; bench owns the core side.
// Notes:   Core inputs stay quiet while they are captured.
`timescale 1ns/10ps
`default_nettype none
`include "jtc_consts.svh"
module jtag_tap_instruction_control_test;
  // Identification value is arbitrary.
  localparam logic [31:0] ID_VAL = 32'h1357_9bdf;
  logic sys_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic tck, trstN, tms, tdi, tdoOut, tdoOe;
  logic highzCtrl, ioCsrShift, ioCsrData, reconfigTrigger, ioCsrSelect;
  logic [3:0] coreOutputValue = 4'h0, coreOutputEnable = 4'h0;
  logic [3:0] keeperEnable = 4'h0, pinIn = 4'h0, pinOut, pinOe, pinKeeperOn;
  logic [31:0] userCode = 32'h0, din, dout;
  logic [9:0] codes [5] = '{10'h3ff, 10'h00a, 10'h00d, 10'h2c5, 10'h00b};
  int error_cnt = 0, checks = 0, pulses = 0, seed = 32'h682c;
  int base = 0, csrCnt = 0;
  logic [31:0] csrBits = 32'h0;

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (reconfigTrigger === 1'h1) begin
      pulses <= pulses + 1;
    end
  end
  // Collects the configuration chain stream as it leaves the block.
  always @(posedge tck) begin
    if (ioCsrShift === 1'h1) begin
      csrCnt <= csrCnt + 1;
      csrBits <= {ioCsrData, csrBits[31:1]};
    end
  end

  jtc_host_model u_host (.tck, .trstN, .tms, .tdi, .tdoOut, .tdoOe);
  jtc_tap_ctrl #(.PIN_COUNT(4), .ID_CODE(ID_VAL)) u_dut (
    .tck, .trstN, .tms, .tdi, .tdoOut, .tdoOe, .sys_clk, .sys_rst,
    .coreOutputValue, .coreOutputEnable, .keeperEnable, .pinIn, .userCode,
    .pinOut, .pinOe, .pinKeeperOn, .highzCtrl, .ioCsrShift, .ioCsrData,
    .reconfigTrigger, .ioCsrSelect);

  function automatic logic [11:0] chain_exp(input logic [3:0] p, e, v);
    logic [11:0] c;
    for (int i = 0; i < 4; i++) c[3*i +: 3] = {v[i], e[i], p[i]};
    return c;
  endfunction

  function automatic logic [3:0] pick(input logic [11:0] d, input int k);
    logic [3:0] r;
    for (int i = 0; i < 4; i++) r[i] = d[3*i + k];
    return r;
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic load(input logic [9:0] code);
    u_host.scan(1'h1, 10, {22'h0, code}, dout);
    chk("irCapture", 32'h1, {30'h0, dout[1:0]});
  endtask

  task automatic shift_dr(input int n);
    din = $random(seed);
    u_host.scan(1'h0, n, din, dout);
    chk("tdoOe", 32'h0, {31'h0, tdoOe});
  endtask

  task automatic settle();
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic stop_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'h0;
    u_host.reset_tap(1'h1);
    shift_dr(32);
    chk("idcode", ID_VAL, dout);
    $display("reset test done");
    foreach (codes[k]) begin
      load(codes[k]);
      shift_dr(8);
      chk("bypass", {24'h0, din[6:0], 1'h0}, dout & 32'hff);
      if (codes[k] == 10'h00d) begin
        settle();
        chk("ioCsrSelect", 32'h1, {31'h0, ioCsrSelect});
        chk("ioCsrShift", 32'h8, csrCnt);
        chk("ioCsrData", {24'h0, din[7:0]}, {24'h0, csrBits[31:24]});
      end
    end
    @(negedge sys_clk);
    keeperEnable = 4'($random(seed));
    // Core asks to drive every pin, so only the floating mode can clear the enables.
    coreOutputEnable = 4'hf;
    settle();
    chk("highzCtrl", 32'h1, {31'h0, highzCtrl});
    chk("pinOe", 32'h0, {28'h0, pinOe});
    chk("pinKeeperOn", {28'h0, keeperEnable}, {28'h0, pinKeeperOn});
    chk("ioCsrSelect", 32'h0, {31'h0, ioCsrSelect});
    $display("bypass test done");
    userCode = $random(seed);
    {pinIn, coreOutputEnable, coreOutputValue} = 12'($random(seed));
    load(`JTC_INSTR_USERCODE);
    shift_dr(32);
    chk("userCode", userCode, dout);
    load(`JTC_INSTR_SAMPLE);
    shift_dr(12);
    chk("sample", {20'h0, chain_exp(pinIn, coreOutputEnable, coreOutputValue)},
        dout & 32'hfff);
    settle();
    chk("pinOe", {28'h0, coreOutputEnable}, {28'h0, pinOe});
    chk("pinOut", {28'h0, coreOutputValue}, {28'h0, pinOut});
    load(`JTC_INSTR_EXTEST);
    settle();
    chk("pinOut", {28'h0, pick(din[11:0], 2)}, {28'h0, pinOut});
    chk("pinOe", {28'h0, ~pick(din[11:0], 1)}, {28'h0, pinOe});
    $display("boundary test done");
    base = pulses;
    load(`JTC_INSTR_RECONFIG);
    settle();
    chk("pulses", 32'h1, pulses - base);
    for (int p = 0; p < 2; p++) begin
      load(`JTC_INSTR_BYPASS);
      u_host.reset_tap(p[0]);
      shift_dr(32);
      chk("idcode", ID_VAL, dout);
    end
    $display("reset path test done");
    stop_test();
  end
endmodule
`default_nettype wire
